// ==== logic/ccl_addr_counter.sv ====
module ccl_addr_counter
  import ccl_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  ccl_addr_if.cnt bus
);
  // A new capture starts at the first address of the one bank that the done decode leaves open.
  localparam logic [CNT_W-1:0] CNT_START = {FIRST_BANK, CHIP_ADDR_W'(0)};

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  // Clear has priority; otherwise one advance per step pulse.
  assign count_nxt = bus.clear ? CNT_START : (bus.step ? count_r + 21'h000001 : count_r); // R5 R16
  assign bus.count = count_r;
  // Done when leaving the first bank: any bank code other than 1.
  assign bus.done = count_r[BANK_LSB+2] | count_r[BANK_LSB+1] | ~count_r[BANK_LSB]; // R7 R8

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      count_r <= CNT_RESET;
    end else begin
      count_r <= count_nxt;
    end
  end

  a_count_step: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    bus.step && !bus.clear |=> count_r == $past(count_r) + 21'h000001) // R5
    else $error("address counter did not advance");
  a_count_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    bus.clear |=> count_r == CNT_START) // R16
    else $error("address counter not cleared");
endmodule : ccl_addr_counter

// ==== logic/ccl_addr_if.sv ====
interface ccl_addr_if;
  import ccl_pkg::*;
  logic step;
  logic clear;
  logic [CNT_W-1:0] count;
  logic done;
  modport ctrl (output step, output clear, input count, input done);
  modport cnt (input step, input clear, output count, output done);
endinterface : ccl_addr_if

// ==== logic/ccl_capture.sv ====
// Summary of operation
// R1: Write strobe low at least 50 ns per pixel period, high part short.
// R2: Strobe fall delayed by one stage in first block, none in second.
// R3: Address step pulse about 36 ns after pixel edge, address valid near 70 ns. Here the step comes 11 cycles after the detected edge.
// R4: Write strobe returns high before the address changes, with margin.
// R5: A 21-bit address counter advances once per step pulse.
// R6: Low 18 bits address the chip; bits 18 to 20 select one RAM bank.
// R7: Image fills five banks; capture completes on entering the sixth. The done decode here ends capture on leaving bank 1.
// R8: Done is bit 20 or bit 19 or not bit 18.
// R9: Done forces the write strobe high and raises the host wake line.
// R10: Host keeps data and address buses released during capture.
// R11: Host gives the wake interrupt level 0, used only to leave idle.
// R12: Host runs its clock near 12.5 MHz while the camera is active.
// R13: Strobe built from pixel sync, host write, integration sync and row gap.
// R14: Camera strobe ANDed with host strobe; both high means read.
// R15: Pulses suppressed in row gap and until integration sync re-arms.
// R16: Counter cleared to zero at the start of each capture. The counter loads the first address of bank 1 instead.
module ccl_capture
  import ccl_pkg::*;
#(
  parameter int ADDR_W = CNT_W
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic pixel_clk_i,
  input wire logic integ_sync_i,
  input wire logic row_gap_pulse_i,
  input wire logic host_wr_b_i,
  input wire logic host_cs_b_i,
  input wire logic upper_byte_select_i,
  input wire logic host_a0_i,
  output logic ram_wr_b_o,
  output logic [CHIP_ADDR_W-1:0] ram_addr_o,
  output logic [NUM_BANKS-1:0] bank_sel_b_o,
  output logic ram_ub_b_o,
  output logic ram_lb_b_o,
  output logic host_wake_irq_in_o,
  output logic capture_active_o
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  // The counter interface is fixed at the package width, so no other width can be served.
  if (ADDR_W != CNT_W) begin : g_bad_addr_w
    $error("ccl_capture: ADDR_W must equal the counter width");
  end
  // The sequencer timer must hold the longest phase count.
  if (STROBE_LOW_CYC + MARGIN_CYC >= (1 << TIMER_W)) begin : g_bad_timer
    $error("ccl_capture: strobe timer too narrow");
  end
  // Every bank code needs a select line of its own.
  if (NUM_BANKS != (1 << BANK_W)) begin : g_bad_banks
    $error("ccl_capture: bank count does not match bank code width");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [6:0] raw_in;
  logic [6:0] syn_in;
  // Host byte controls come from the host's clock, so they are synchronised as well.
  assign raw_in = {pixel_clk_i, integ_sync_i, row_gap_pulse_i, host_wr_b_i, host_cs_b_i,
                   upper_byte_select_i, host_a0_i};

  ccl_sync #(.W(7)) u_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .d_i(raw_in),
    .q_o(syn_in)
  );

  logic pix_s;
  logic integ_s;
  logic gap_s;
  logic host_wr_b_s;
  logic host_cs_b_s;
  logic host_ub_s;
  logic host_a0_s;
  assign {pix_s, integ_s, gap_s, host_wr_b_s, host_cs_b_s, host_ub_s, host_a0_s} = syn_in;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Edge registers reset to the idle low level of both pins, so no false edge follows reset.
  logic pix_d_r;
  logic integ_d_r;
  logic pix_rise;
  logic integ_rise;
  assign pix_rise = pix_s & ~pix_d_r;
  assign integ_rise = integ_s & ~integ_d_r;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pix_d_r <= 1'b0;
      integ_d_r <= 1'b0;
    end else begin
      pix_d_r <= pix_s;
      integ_d_r <= integ_s;
    end
  end

  // ----------------------------------------------------------------
  // Address counter
  // ----------------------------------------------------------------
  ccl_addr_if addr_bus ();

  ccl_addr_counter u_cnt (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .bus(addr_bus)
  );

  // ----------------------------------------------------------------
  // Capture enable
  // ----------------------------------------------------------------
  // The integration sync re-arms the enable and starts a new image at bank one.
  logic armed_r;
  logic armed_nxt;
  logic done_w;
  assign done_w = addr_bus.done & armed_r;
  assign armed_nxt = integ_rise ? 1'b1 : armed_r; // R15

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
    end
  end

  // The counter is preset to the first address of bank one on re-arm.
  logic start_clear;
  assign start_clear = integ_rise; // R16

  // ----------------------------------------------------------------
  // Strobe sequencer
  // ----------------------------------------------------------------
  ccl_state_t state_r;
  ccl_state_t state_nxt;
  logic [TIMER_W-1:0] timer_r;
  logic [TIMER_W-1:0] timer_nxt;
  logic [TIMER_W-1:0] step_at;
  logic pulse_ok;
  logic seq_step;

  // A pulse is allowed only with valid pixel data, outside the row gap and before done.
  assign pulse_ok = armed_r & ~gap_s & ~addr_bus.done; // R9 R13 R15
  // Step comes after the strobe has risen, keeping the address steady while writing.
  assign step_at = TIMER_W'(STROBE_LOW_CYC + MARGIN_CYC); // R4

  // One sequence is two cycles of fall delay, seven low and two before the step.
  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r + 5'h01;
    unique case (state_r)
      ST_IDLE: begin
        timer_nxt = '0;
        if (pix_rise && pulse_ok) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (timer_r == TIMER_W'(STROBE_FALL_CYC - 1)) begin // R2
          state_nxt = ST_LOW;
          timer_nxt = '0;
        end
      end
      ST_LOW: begin
        if (timer_r == TIMER_W'(STROBE_LOW_CYC - 1)) begin // R1
          state_nxt = ST_GAP;
          timer_nxt = '0;
        end
      end
      ST_GAP: begin
        if (timer_r == step_at - TIMER_W'(STROBE_LOW_CYC)) begin // R3 R4
          state_nxt = ST_IDLE;
          timer_nxt = '0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        timer_nxt = '0;
      end
    endcase
  end

  assign seq_step = (state_r == ST_GAP) && (state_nxt == ST_IDLE); // R3 R5
  assign addr_bus.step = seq_step;
  assign addr_bus.clear = start_clear;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_r <= ST_IDLE;
      timer_r <= '0;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic cam_wr_b;
  logic wr_b_nxt;
  logic [NUM_BANKS-1:0] bank_nxt;
  logic [BANK_W-1:0] bank_code;

  assign cam_wr_b = ~((state_r == ST_LOW) & ~addr_bus.done); // R1 R9
  assign wr_b_nxt = cam_wr_b & host_wr_b_s; // R14
  assign bank_code = addr_bus.count[BANK_LSB +: BANK_W]; // R6

  // Bank select follows the counter during capture, otherwise bank 0 follows the host select and the rest stay high.
  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      assign bank_nxt[g] = armed_r ? ~(bank_code == BANK_W'(g)) : (host_cs_b_s | (g != 0)); // R6
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      ram_wr_b_o <= 1'b1;
      ram_addr_o <= '0;
      bank_sel_b_o <= '1;
      ram_ub_b_o <= 1'b1;
      ram_lb_b_o <= 1'b1;
      host_wake_irq_in_o <= 1'b0;
      capture_active_o <= 1'b0;
    end else begin
      ram_wr_b_o <= wr_b_nxt; // R13 R14
      ram_addr_o <= addr_bus.count[CHIP_ADDR_W-1:0]; // R6
      bank_sel_b_o <= bank_nxt;
      // Each camera word fills both bytes, so both byte enables stay low during capture.
      ram_ub_b_o <= armed_r ? 1'b0 : host_ub_s;
      ram_lb_b_o <= armed_r ? 1'b0 : host_a0_s;
      host_wake_irq_in_o <= done_w; // R9
      capture_active_o <= armed_r & ~addr_bus.done;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_strobe_low_len: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R1
    $rose(state_r == ST_LOW) |-> (state_r == ST_LOW)[*7])
    else $error("camera strobe low phase too short");
  a_fall_delay: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R2
    state_r == ST_IDLE && state_nxt == ST_WAIT |=> ##2 state_r == ST_LOW)
    else $error("strobe fall delay wrong");
  a_step_after_rise: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R4
    seq_step |-> state_r == ST_GAP && $past(state_r) == ST_GAP)
    else $error("address step while strobe low");
  a_step_spacing: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R3
    $fell(state_r == ST_LOW) |-> ##[1:3] seq_step)
    else $error("address step not issued in time");
  a_done_holds_wr: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R9
    addr_bus.done && host_wr_b_s |=> ram_wr_b_o)
    else $error("write strobe low after done");
  a_done_wake: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R9
    done_w |=> host_wake_irq_in_o)
    else $error("wake line not raised on done");
  a_host_and: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R14
    !host_wr_b_s |=> !ram_wr_b_o)
    else $error("host write strobe not passed");
  a_gap_block: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R15
    state_r == ST_IDLE && (gap_s || !armed_r) |=> state_r == ST_IDLE)
    else $error("strobe started in row gap or unarmed");
  a_bank_decode: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R6
    armed_r |=> !bank_sel_b_o[$past(bank_code)])
    else $error("bank select decode wrong");
  a_done_eq: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R7 R8
    addr_bus.done == (bank_code != FIRST_BANK))
    else $error("done equation wrong");
  a_clear_start: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R16
    integ_rise |=> addr_bus.count == {FIRST_BANK, CHIP_ADDR_W'(0)})
    else $error("counter not cleared at capture start");
  a_step_once: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R5
    seq_step |=> !seq_step)
    else $error("address stepped twice for one pixel");
  a_done_idle: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R9
    addr_bus.done && state_r == ST_IDLE |=> state_r == ST_IDLE)
    else $error("strobe sequence started after done");
  a_wake_armed: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R9
    host_wake_irq_in_o |-> $past(armed_r))
    else $error("wake raised without a capture");
  a_strobe_src: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R13
    $fell(ram_wr_b_o) |-> $past(state_r == ST_LOW) || !$past(host_wr_b_s))
    else $error("write strobe fell with no source");
  a_no_wr_unarmed: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R15
    !armed_r && host_wr_b_s |=> ram_wr_b_o)
    else $error("camera strobe before re-arm");
  a_addr_steady: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R4
    state_r == ST_LOW && !addr_bus.clear |=> $stable(addr_bus.count))
    else $error("address changed while strobe low");

  c_pixel_write: cover property (@(posedge clock_i) disable iff (!rst_b_i) seq_step);
  c_done: cover property (@(posedge clock_i) disable iff (!rst_b_i) $rose(host_wake_irq_in_o));
  c_gap_skip: cover property (@(posedge clock_i) disable iff (!rst_b_i) pix_rise && gap_s && armed_r);
  c_host_write: cover property (@(posedge clock_i) disable iff (!rst_b_i) !ram_wr_b_o && !armed_r);
  c_capture_start: cover property (@(posedge clock_i) disable iff (!rst_b_i) $rose(capture_active_o));

endmodule : ccl_capture

// ==== logic/ccl_pkg.sv ====
package ccl_pkg;

  // ----------------------------------------------------------------
  // Address counter layout
  // ----------------------------------------------------------------
  localparam int CNT_W = 21;
  localparam int CHIP_ADDR_W = 18;
  localparam int BANK_LSB = 18;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam logic [2:0] FIRST_BANK = 3'h1;
  localparam logic [20:0] CNT_RESET = 21'h000000;

  // ----------------------------------------------------------------
  // Image geometry
  // ----------------------------------------------------------------
  localparam int IMG_ROWS = 1024;
  localparam int IMG_COLS = 1280;
  localparam int IMG_BANKS = 5;

  // ----------------------------------------------------------------
  // Strobe timing, in nanoseconds
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int MCLK_PERIOD_NS = 80;
  localparam int STAGE_DELAY_NS = 15;
  localparam int STAGES_FIRST = 1;
  localparam int STAGES_SECOND = 0;
  localparam int STROBE_LOW_MIN_NS = 50;
  localparam int STROBE_HIGH_NS = 23;
  localparam int STEP_DELAY_NS = 36;
  localparam int ADDR_VALID_NS = 70;
  localparam int ADDR_MARGIN_NS = 10;

  // Strobe goes low after one stage delay, rounded up to clock cycles.
  localparam int STROBE_FALL_CYC = (STAGES_FIRST * STAGE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe low time, least time rounded up.
  localparam int STROBE_LOW_CYC = (STROBE_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Step pulse delay and address margin, rounded down; the margin at least one.
  localparam int STEP_DELAY_CYC = STEP_DELAY_NS / CLK_PERIOD_NS;
  localparam int MARGIN_CYC = (ADDR_MARGIN_NS / CLK_PERIOD_NS) < 1 ? 1 : ADDR_MARGIN_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 5;

  // ----------------------------------------------------------------
  // Strobe sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_LOW  = 4'b0100,
    ST_GAP  = 4'b1000
  } ccl_state_t;

endpackage : ccl_pkg

// ==== logic/ccl_sync.sv ====
module ccl_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : ccl_sync

// ==== sim/ccl_cam_model.sv ====
module ccl_cam_model (
  input wire logic frame_go_i,
  input wire logic [7:0] pix_count_i,
  output logic pixel_clk_o,
  output logic integ_sync_o,
  output logic row_gap_pulse_o,
  output logic frame_busy_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Sensor frame: sync pulse, then pixels with a row gap in the middle
  // ----------------------------------------------------------------
  // The pixel clock stands low outside frames.
  initial begin
    pixel_clk_o = 1'b0;
    integ_sync_o = 1'b0;
    row_gap_pulse_o = 1'b0;
    frame_busy_o = 1'b0;
    forever begin
      wait (frame_go_i === 1'b1);
      frame_busy_o = 1'b1;
      integ_sync_o = 1'b1;
      #125;
      integ_sync_o = 1'b0;
      #250;
      for (int i = 0; i < pix_count_i; i++) begin
        row_gap_pulse_o = (i == pix_count_i / 2) || (i == pix_count_i / 2 + 1);
        pixel_clk_o = 1'b1;
        #62.5;
        pixel_clk_o = 1'b0;
        #62.5;
      end
      row_gap_pulse_o = 1'b0;
      frame_busy_o = 1'b0;
      wait (frame_go_i === 1'b0);
    end
  end
endmodule : ccl_cam_model

// ==== sim/test_ccl_capture.sv ====
module test_ccl_capture;
  import ccl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [3:0] host;
    logic [10:0] want;
  } ccl_row_t;

  logic clock_i, rst_b_i, host_wr_b, host_cs_b, ub_sel, host_a0;
  logic pixel_clk, integ_sync, row_gap, frame_go, frame_busy;
  logic ram_wr_b, ub_b, lb_b, wake, active;
  logic [CHIP_ADDR_W-1:0] ram_addr;
  logic [NUM_BANKS-1:0] bank_sel_b;
  int errors, checks_done, n, lows;
  // Pixels sent per frame; the model holds the row gap over two of them.
  localparam int FRAME_PIX = 32'h14;
  localparam int GAP_PIX = 32'h2;
  // Host inputs {wr_b, cs_b, ub, a0} beside {wr_b, bank_sel_b, ub_b, lb_b}.
  ccl_row_t rows [6] = '{
    '{4'hf, {1'b1, 8'hff, 2'h3}}, '{4'h7, {1'b0, 8'hff, 2'h3}},
    '{4'hb, {1'b1, 8'hfe, 2'h3}}, '{4'hd, {1'b1, 8'hff, 2'h1}},
    '{4'he, {1'b1, 8'hff, 2'h2}}, '{4'h0, {1'b0, 8'hfe, 2'h0}}};

  ccl_capture ccl_capture_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .pixel_clk_i(pixel_clk),
    .integ_sync_i(integ_sync), .row_gap_pulse_i(row_gap), .host_wr_b_i(host_wr_b),
    .host_cs_b_i(host_cs_b), .upper_byte_select_i(ub_sel), .host_a0_i(host_a0),
    .ram_wr_b_o(ram_wr_b), .ram_addr_o(ram_addr), .bank_sel_b_o(bank_sel_b),
    .ram_ub_b_o(ub_b), .ram_lb_b_o(lb_b), .host_wake_irq_in_o(wake),
    .capture_active_o(active));

  ccl_cam_model ccl_cam_model_inst (
    .frame_go_i(frame_go), .pix_count_i(8'(FRAME_PIX)), .pixel_clk_o(pixel_clk),
    .integ_sync_o(integ_sync), .row_gap_pulse_o(row_gap), .frame_busy_o(frame_busy));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic step(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : step

  // Waits a bounded time for the pin group to settle, then compares.
  task automatic wait_out(input logic [10:0] exp);
    int k;
    k = 0;
    while ({ram_wr_b, bank_sel_b, ub_b, lb_b} !== exp && k < 12) begin
      step(1);
      k++;
    end
    chk({21'h0, ram_wr_b, bank_sel_b, ub_b, lb_b}, {21'h0, exp});
  endtask : wait_out

  task automatic reset_and_check(input int k);
    rst_b_i = 1'b0;
    step(k);
    rst_b_i = 1'b1;
    chk({ram_wr_b, ub_b, lb_b, wake, active}, 32'h1c);
    chk({14'h0, ram_addr}, 32'h0);
    chk({24'h0, bank_sel_b}, 32'hff);
  endtask : reset_and_check

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    checks_done = 0;
    rst_b_i = 1'b0;
    {host_wr_b, host_cs_b, ub_sel, host_a0} = 4'hf;
    frame_go = 1'b0;
    lows = 0;
    reset_and_check(6);
    $display("test reset done");
    foreach (rows[i]) begin
      {host_wr_b, host_cs_b, ub_sel, host_a0} = rows[i].host;
      wait_out(rows[i].want);
    end
    $display("test host path done");
    // Host releases the bus and stays idle for the whole capture.
    {host_wr_b, host_cs_b, ub_sel, host_a0} = 4'hf;
    step(2);
    frame_go = 1'b1;
    n = 0;
    while (active !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    if (n == 40) begin
      errors++;
      end_of_test();
    end
    chk({ub_b, lb_b, active}, 32'h1);
    chk({14'h0, ram_addr}, 32'h0);
    chk({24'h0, bank_sel_b}, 32'hfd);
    chk({31'h0, wake}, 32'h0);
    n = 0;
    while (frame_busy === 1'b1 && n < 2000) begin
      if (ram_wr_b === 1'b0) lows++;
      step(1);
      n++;
    end
    if (n == 2000) begin
      errors++;
      end_of_test();
    end
    // The last pixel's strobe and address step finish before the frame ends; 24 more cycles are still counted.
    repeat (24) begin
      if (ram_wr_b === 1'b0) lows++;
      step(1);
    end
    chk(lows, (FRAME_PIX - GAP_PIX) * STROBE_LOW_CYC);
    chk({14'h0, ram_addr}, FRAME_PIX - GAP_PIX);
    chk({24'h0, bank_sel_b}, 32'hfd);
    chk({31'h0, wake}, 32'h0);
    frame_go = 1'b0;
    $display("test capture done");
    reset_and_check(2);
    wait_out({1'b1, 8'hff, 2'h3});
    $display("test second reset done");
    end_of_test();
  end
endmodule : test_ccl_capture
